// >>> dv/psc_checker.sv
// Port-level assertions for the pin select block
`timescale 1ns/100ps
module psc_checker (
   // Clock, reset and access bus
   input logic clock, rstn, cfg_req, cfg_wr, cfg_ack,
   input logic [31:0] cfg_addr, cfg_rdata,
   // Enables and pin ownership
   input logic host_port_enable, host_bus_width, audio_one_enable,
   input logic buffered_serial_one_enable, buffered_serial_zero_enable,
   input logic shared_audio_to_audio, shared_io_to_host, shared_io_to_io,
   input logic host_only_pins_active
);
   logic [1:0] age;
   wire hit = cfg_req && cfg_addr[31:12] == 20'h01b3f;
   wire ctl = cfg_req && cfg_addr == 32'h01b3f000;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Ownership settles two edges after release, so wait three
   always_ff @(posedge clock or negedge rstn)
      if (!rstn) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   property p_ack; hit |=> cfg_ack; endproperty
   a_ack: assert property (p_ack)
      else $error("ack missing");
   property p_miss; !hit |=> !cfg_ack; endproperty
   a_miss: assert property (p_miss)
      else $error("stray ack");
   property p_fix; buffered_serial_one_enable && buffered_serial_zero_enable;
   endproperty
   a_fix: assert property (p_fix)
      else $error("serial enable low");
   property p_rd;
      ctl && !cfg_wr |=> cfg_rdata[31:11] == 0 && cfg_rdata[6:4] == 3'h0
         && cfg_rdata[2:1] == 2'h3;
   endproperty
   a_rd: assert property (p_rd)
      else $error("fixed bits wrong");
   property p_own; age == 2'h3 |-> host_port_enable == host_only_pins_active
      && host_port_enable != shared_io_to_io; endproperty
   a_own: assert property (p_own)
      else $error("ownership split");
   property p_wide; shared_io_to_host |-> host_bus_width && !audio_one_enable;
   endproperty
   a_wide: assert property (p_wide)
      else $error("wide host shares");
   property p_hold; age == 2'h3 |-> $stable({host_port_enable, host_bus_width});
   endproperty
   a_hold: assert property (p_hold)
      else $error("strap mode moved");
   property p_a1; shared_audio_to_audio == audio_one_enable; endproperty
   a_a1: assert property (p_a1)
      else $error("audio pins differ");
   cover property (ctl && cfg_wr);
   cover property (hit && !cfg_wr ##1 cfg_ack);
   cover property (shared_io_to_io);
endmodule // psc_checker

// >>> dv/tb_peripheral_pin_select_config.sv
// Self-checking bench for the pin select block
`timescale 1ns/100ps
module tb_peripheral_pin_select_config;
   logic clock = 0, rstn = 0, sel = 0, wid = 0, req = 0, wr = 0, s, w, gack;
   logic [31:0] addr = 0, wdata = 0, rdata, lf = 32'h16a6, mdl, d, got;
   logic ack, hpe, hbw, a1, a0, i1, i0, b1, b0, sah, saa, sih, sii, ho;
   logic [1:0] cp;
   int n_fail = 0, compares = 0;
   always #20 clock = ~clock;
   psc_pin_select u_dut (.clock(clock), .rstn(rstn),
      .host_port_select_strap(sel), .host_width_strap(wid),
      .cfg_req(req), .cfg_wr(wr), .cfg_addr(addr), .cfg_wdata(wdata),
      .cfg_rdata(rdata), .cfg_ack(ack), .host_port_enable(hpe),
      .host_bus_width(hbw), .audio_one_enable(a1), .audio_zero_enable(a0),
      .i2c_ctrl_one_enable(i1), .i2c_ctrl_zero_enable(i0),
      .buffered_serial_one_enable(b1), .buffered_serial_zero_enable(b0),
      .audio_clock_pair_select(cp), .shared_audio_to_host(sah),
      .shared_audio_to_audio(saa), .shared_io_to_host(sih),
      .shared_io_to_io(sii), .host_only_pins_active(ho));
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string nm, logic [31:0] sn, logic [31:0] ex);
      compares++;
      if (sn !== ex) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, ex, sn);
      end
   endtask
   // Request stands one cycle; the answer is read just after the taking edge
   task automatic acc(logic rw, logic [31:0] a, logic [31:0] dv);
      @(posedge clock);
      req <= 1;
      wr <= rw;
      addr <= a;
      wdata <= dv;
      @(posedge clock);
      req <= 0;
      #1 got = rdata;
      gack = ack;
   endtask
   task automatic complete_run;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      for (int m = 0; m < 4; m++) begin
         s = m[1];
         w = m[0];
         @(posedge clock);
         rstn <= 0;
         sel <= s;
         wid <= w;
         repeat (6) @(posedge clock);
         rstn <= 1;
         repeat (2) @(posedge clock);
         sel <= !s; // Late strap moves must be ignored
         wid <= !w;
         mdl = 32'h6;
         acc(0, 32'h01b3f000, 0);
         chk("reset read", got, mdl);
         chk("own", {hpe, hbw, sah, sih, sii, ho},
            {!s, !s & w, !s & w, !s & w, s, !s});
         for (int i = 0; i < 6; i++) begin
            lf = nx(lf);
            d = {21'h0, i[1:0], lf[8:7], 3'h0, lf[3:0]};
            acc(1, 32'h01b3f000, d);
            chk("wr ack", gack, 1);
            mdl = d & 32'h789 | 32'h6;
            @(posedge clock);
            #1 chk("en", {cp, a1, saa, i1, i0, b1, b0, a0}, {mdl[10:9],
               mdl[8] & (s | !w), mdl[8] & (s | !w), mdl[7], mdl[3], 2'h3,
               mdl[0]});
            acc(0, 32'h01b3f000, 0);
            chk("rd", got, mdl);
         end
      end
      acc(1, 32'h01b3f004, lf);
      acc(0, 32'h01b3f004, 0);
      chk("gap rd", got, 0);
      chk("gap ack", gack, 1);
      acc(0, 32'h01b4f000, 0);
      chk("miss ack", gack, 0);
      acc(0, 32'h01b3f000, 0);
      chk("ctrl kept", got, mdl);
      complete_run;
   end
endmodule // tb_peripheral_pin_select_config
bind psc_pin_select psc_checker u_chk (.clock(clock), .rstn(rstn),
   .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_ack(cfg_ack),
   .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
   .host_port_enable(host_port_enable), .host_bus_width(host_bus_width),
   .audio_one_enable(audio_one_enable),
   .buffered_serial_one_enable(buffered_serial_one_enable),
   .buffered_serial_zero_enable(buffered_serial_zero_enable),
   .shared_audio_to_audio(shared_audio_to_audio),
   .shared_io_to_host(shared_io_to_host), .shared_io_to_io(shared_io_to_io),
   .host_only_pins_active(host_only_pins_active));

// >>> hdl/psc_consts.vh
// Constants for the peripheral pin select configuration block
`ifndef PSC_CONSTS_VH
`define PSC_CONSTS_VH
`define PSC_BLOCK_BASE 32'h01b3f000
`define PSC_BLOCK_MASK 32'hfffff000
`define PSC_CTRL_ADDR 32'h01b3f000
`define PSC_A1EN_BIT 8
`define PSC_I1EN_BIT 7
`define PSC_I0EN_BIT 3
`define PSC_BS1_BIT 2
`define PSC_BS0_BIT 1
`define PSC_A0EN_BIT 0
`define PSC_CLKSEL_LO 9
`define PSC_CLKSEL_HI 10
`define PSC_CTRL_RESET 32'h00000006
`define PSC_CTRL_WMASK 32'h00000789
`define PSC_CTRL_FIXED1 32'h00000006
`define PSC_NARROW_W 16
`define PSC_WIDE_W 32
`endif

// >>> hdl/psc_pin_select.v
// Peripheral pin sharing and peripheral enable configuration
// Notes on behaviour
// R1: Latch host-port select strap at reset; hold.
// R2: Select 0, width 0: narrow host, audio one.
// R3: Select 0, width 1: wide host owns all.
// R4: Select 1: audio one and io bank own.
// R5: Software sets io enable/direction before io use.
// R6: Select default enables host; no software change.
// R7: Registers live in 4K block at base.
// R8: Reserved bits read-only; software writes zero.
// R9: Bits 10:9 choose audio rx clock pair.
// R10: Bit 8 enables audio one, reset clear.
// R11: Bit 7 enables i2c controller one.
// R12: Bit 3 enables i2c controller zero.
// R13: Bits 2,1 serial enables read one always.
// R14: Bit 0 enables audio port zero.
// R15: Audio and i2c disabled after power-up.
// R16: Latch host width strap with select strap.
// R17: Reads return stored bits, fixed ones, zeros.
// R18: Deselected peripheral drives no shared output.
`timescale 1ns/100ps
`include "psc_consts.vh"
module psc_pin_select (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Reset-time straps
   input wire host_port_select_strap,
   input wire host_width_strap,
   // Configuration access bus
   input wire cfg_req,
   input wire cfg_wr,
   input wire [31:0] cfg_addr,
   input wire [31:0] cfg_wdata,
   output reg [31:0] cfg_rdata,
   output reg cfg_ack,
   // Peripheral enables
   output reg host_port_enable,
   output reg host_bus_width,
   output reg audio_one_enable,
   output reg audio_zero_enable,
   output reg i2c_ctrl_one_enable,
   output reg i2c_ctrl_zero_enable,
   output reg buffered_serial_one_enable,
   output reg buffered_serial_zero_enable,
   output reg [1:0] audio_clock_pair_select,
   // Shared pin ownership
   output reg shared_audio_to_host,
   output reg shared_audio_to_audio,
   output reg shared_io_to_host,
   output reg shared_io_to_io,
   output reg host_only_pins_active
);

   wire [1:0] strap_q;
   reg capture;
   reg [1:0] ctrl_clksel;
   reg ctrl_a1;
   reg ctrl_i1;
   reg ctrl_i0;
   reg ctrl_a0;
   reg [31:0] next_rdata;
   wire hit;
   wire sel_is_audio;
   wire wide;
   wire [1:0] mode;
   reg next_host_en;
   reg next_host_wide;
   reg next_audio_one;
   reg next_sa_host;
   reg next_si_host;
   reg next_si_io;
   reg next_host_only;

   // Mode codes are {select strap, width strap} as latched
   localparam [1:0] MODE_NARROW = 2'b00;
   localparam [1:0] MODE_WIDE = 2'b01;
   localparam [1:0] MODE_AUDIO_N = 2'b10;
   localparam [1:0] MODE_AUDIO_W = 2'b11;

   // Capture enable held high in reset; the straps are taken at the first edge after release
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         capture <= 1'b1;
      end else begin
         capture <= 1'b0;
      end
   end

   // Capture continues into the first cycle after release, then freezes
   psc_strap_latch #(.WIDTH(2)) u_strap (
      .clock(clock),
      .rstn(rstn),
      .strap_in({host_width_strap, host_port_select_strap}),
      .capture(capture),
      .strap_q(strap_q)
   ); // [R1] [R16] [R6]

   assign sel_is_audio = strap_q[0];
   assign wide = strap_q[1];
   assign mode = {sel_is_audio, wide};

   function [31:0] read_word;
      input [1:0] clksel;
      input a1;
      input i1;
      input i0;
      input a0;
      begin
         read_word = `PSC_CTRL_FIXED1;
         read_word[`PSC_CLKSEL_HI:`PSC_CLKSEL_LO] = clksel;
         read_word[`PSC_A1EN_BIT] = a1;
         read_word[`PSC_I1EN_BIT] = i1;
         read_word[`PSC_I0EN_BIT] = i0;
         read_word[`PSC_A0EN_BIT] = a0;
      end
   endfunction

   // Only the control word is mapped; the rest of the block reads zero
   function is_ctrl;
      input [31:0] addr;
      begin
         is_ctrl = (addr == `PSC_CTRL_ADDR);
      end
   endfunction

   assign hit = ((cfg_addr & `PSC_BLOCK_MASK) == `PSC_BLOCK_BASE); // [R7]

   always @* begin
      next_rdata = 32'h00000000;
      if (cfg_req && !cfg_wr && is_ctrl(cfg_addr)) begin
         // Reserved bits zero, serial enables one
         next_rdata = read_word(ctrl_clksel, ctrl_a1, ctrl_i1, ctrl_i0,
            ctrl_a0); // [R17] [R8] [R13]
      end
   end

   // Writes touch only the writable bits; reserved and fixed are ignored
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_clksel <= 2'h0;
         ctrl_a1 <= 1'b0;
         ctrl_i1 <= 1'b0;
         ctrl_i0 <= 1'b0;
         ctrl_a0 <= 1'b0; // [R15]
         cfg_rdata <= 32'h00000000;
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg_req && hit;
         cfg_rdata <= next_rdata;
         if (cfg_req && cfg_wr && is_ctrl(cfg_addr)) begin
            ctrl_clksel <= cfg_wdata[`PSC_CLKSEL_HI:`PSC_CLKSEL_LO]; // [R9]
            ctrl_a1 <= cfg_wdata[`PSC_A1EN_BIT]; // [R10]
            ctrl_i1 <= cfg_wdata[`PSC_I1EN_BIT]; // [R11]
            ctrl_i0 <= cfg_wdata[`PSC_I0EN_BIT]; // [R12]
            ctrl_a0 <= cfg_wdata[`PSC_A0EN_BIT]; // [R14]
         end
      end
   end

   // Table of pin owners per latched mode; the width strap is ignored
   // once the select strap hands the pins to audio one and the io bank
   always @* begin
      next_host_en = 1'b0;
      next_host_wide = 1'b0;
      next_audio_one = 1'b0;
      next_sa_host = 1'b0;
      next_si_host = 1'b0;
      next_si_io = 1'b0;
      next_host_only = 1'b0;
      case (mode)
         MODE_NARROW: begin
            // Upper host lanes go to audio one; io lanes float
            next_host_en = 1'b1; // [R2]
            next_audio_one = ctrl_a1; // [R2] [R10]
            next_host_only = 1'b1; // [R2]
         end
         MODE_WIDE: begin
            // Wide host takes every shared pin, so audio one stays off
            next_host_en = 1'b1; // [R3]
            next_host_wide = 1'b1; // [R3] [R16]
            next_sa_host = 1'b1; // [R3]
            next_si_host = 1'b1; // [R3]
            next_host_only = 1'b1; // [R3]
         end
         MODE_AUDIO_N, MODE_AUDIO_W: begin
            // Host-only pins stay undriven in this mode
            next_audio_one = ctrl_a1; // [R4] [R10]
            next_si_io = 1'b1; // [R4]
         end
         default: begin
            next_host_en = 1'b0;
         end
      endcase
   end

   // Pin ownership from latched straps; audio one also needs its enable
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         host_port_enable <= 1'b0;
         host_bus_width <= 1'b0;
         audio_one_enable <= 1'b0;
         audio_zero_enable <= 1'b0;
         i2c_ctrl_one_enable <= 1'b0;
         i2c_ctrl_zero_enable <= 1'b0;
         buffered_serial_one_enable <= 1'b1;
         buffered_serial_zero_enable <= 1'b1;
         audio_clock_pair_select <= 2'h0;
         shared_audio_to_host <= 1'b0;
         shared_audio_to_audio <= 1'b0;
         shared_io_to_host <= 1'b0;
         shared_io_to_io <= 1'b0;
         host_only_pins_active <= 1'b0;
      end else begin
         host_port_enable <= next_host_en; // [R2] [R3]
         host_bus_width <= next_host_wide; // [R16]
         audio_one_enable <= next_audio_one; // [R10] [R3]
         audio_zero_enable <= ctrl_a0; // [R14]
         i2c_ctrl_one_enable <= ctrl_i1; // [R11]
         i2c_ctrl_zero_enable <= ctrl_i0; // [R12]
         buffered_serial_one_enable <= 1'b1; // [R13]
         buffered_serial_zero_enable <= 1'b1; // [R13]
         audio_clock_pair_select <= ctrl_clksel; // [R9]
         shared_audio_to_host <= next_sa_host; // [R3]
         // Audio pins stay undriven until audio one is enabled
         shared_audio_to_audio <= next_audio_one; // [R18]
         shared_io_to_host <= next_si_host; // [R3] [R2]
         // Io bank direction still gated by its own registers
         shared_io_to_io <= next_si_io; // [R4]
         host_only_pins_active <= next_host_only; // [R4] [R18]
      end
   end

endmodule // psc_pin_select

// >>> hdl/psc_strap_latch.v
// Strap capture register for the pin select block
`timescale 1ns/100ps
module psc_strap_latch #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Strap levels and hold
   input wire [WIDTH-1:0] strap_in,
   input wire capture,
   output reg [WIDTH-1:0] strap_q
);

   // Reset value is constant; the pin level is taken by clocked capture
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         strap_q <= {WIDTH{1'b0}};
      end else if (capture) begin
         strap_q <= strap_in;
      end
   end

endmodule // psc_strap_latch
